// [msbc_defines.vh]
// constants for the module sideband control block
`ifndef MSBC_DEFINES_VH
`define MSBC_DEFINES_VH
`define MSBC_CLK_HZ            40000000
`define MSBC_RESET_PULSE_NS    1000
`define MSBC_RESET_PULSE_CYC   ((`MSBC_RESET_PULSE_NS * 40 + 999) / 1000)
`define MSBC_RESET_EXEC_US     1000
`define MSBC_RESET_EXEC_CYC    (`MSBC_RESET_EXEC_US * 40)
`define MSBC_POWERUP_MS        2000
`define MSBC_POWERUP_CYC       (`MSBC_POWERUP_MS * 40000)
`define MSBC_CNT_W             27
`endif

// [msbc_host_model.sv]
// host board model: pull-ups on shared lines and flag reads after attention
`timescale 1ns/1ps
module msbc_host_model (
  input  wire clk, attention_n_o, attention_n_oe, module_present_n, sda_o, sda_oe, host_sda_low,
  output wire attn_line, present_line, sda_line,
  output reg  flags_read
);
  assign attn_line    = attention_n_oe ? attention_n_o : 1'b1;
  assign present_line = (module_present_n === 1'b0) ? 1'b0 : 1'b1;
  assign sda_line     = !(host_sda_low | (sda_oe & !sda_o));
  initial flags_read = 1'b0;
  // cause is read over the bus as soon as attention is seen
  always @(posedge clk) flags_read <= !attn_line;
endmodule // msbc_host_model

// [msbc_sideband.v]
// module-side sideband control: select gating, reset, low power, presence, attention
`timescale 1ns/1ps
`include "msbc_defines.vh"
// Overview of operation
// - select low lets management bus commands through and answers go out once the module is functional
// - select high blocks bus traffic and releases the data line
// - an undriven select pin counts as high, module deselected
// - reset held low past minimum width restores all settings to defaults
// - reset execution timing starts at the reset pin rising edge
// - completion shown by attention low with init-pending bit cleared
// - power-up raises the completion attention without a host reset
// - low-power request high puts the module in reduced-power state
// - presence output is tied low while inserted
// - attention driven low on a fault event while functional
// - attention only pulled low, else floating; host pulls it up
// - module fully functional within 2000 ms of power good
module msbc_sideband #(
  parameter [26:0] RESET_PULSE_CYC = `MSBC_RESET_PULSE_CYC,
  parameter [26:0] RESET_EXEC_CYC  = `MSBC_RESET_EXEC_CYC,
  parameter [26:0] POWERUP_CYC     = `MSBC_POWERUP_CYC
) (
  // clock and reset
  input  wire clk,
  input  wire rst,
  // host sideband pins
  input  wire module_select_n_in,
  input  wire module_select_n_oe,
  input  wire module_reset_n,
  input  wire low_power_request,
  output wire module_present_n,
  output wire attention_n_o,
  output reg  attention_n_oe,
  // management bus data line toward host
  input  wire sda_in,
  output reg  sda_oe,
  output wire sda_o,
  // management engine side
  output reg  mgmt_enable,
  output reg  mgmt_sda_in,
  input  wire mgmt_sda_drive_low,
  input  wire fault_event,
  input  wire flags_read,
  output reg  defaults_restore,
  output reg  low_power_mode,
  output reg  init_pending,
  output reg  functional
);
  localparam ST_POWERUP = 2'd0;
  localparam ST_RESET   = 2'd1;
  localparam ST_EXEC    = 2'd2;
  localparam ST_RUN     = 2'd3;

  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [26:0] low_count;
  reg         reset_prev;
  reg         long_low;
  reg         attn_done;
  reg         attn_fault;
  reg         t_start;
  reg  [26:0] t_len;
  reg         pu_kicked;
  wire        pu_start;
  wire [26:0] timer_len;
  wire        timer_go;
  wire        t_done;
  wire        select_active;
  wire        reset_rise;

  // pull-up: undriven select reads high
  assign select_active    = module_select_n_oe & ~module_select_n_in;
  assign reset_rise       = module_reset_n & ~reset_prev;
  assign module_present_n = 1'b0;
  assign attention_n_o    = 1'b0;
  assign sda_o            = 1'b0;
  // one timer serves power-up and reset execution
  assign pu_start         = ~pu_kicked & (state == ST_POWERUP);
  assign timer_len        = pu_start ? POWERUP_CYC : t_len;
  assign timer_go         = pu_start | t_start;

  msbc_timer #(
    .W      (27)
  ) u_timer (
    .clk    (clk),
    .rst    (rst),
    .start  (timer_go),
    .length (timer_len),
    .busy   (),
    .done   (t_done)
  );

  // select gating of the shared bus
  always @(posedge clk) begin
    if (rst) begin
      mgmt_enable <= 1'b0;
      mgmt_sda_in <= 1'b1;
      sda_oe      <= 1'b0;
    end else begin
      mgmt_enable <= select_active & functional;
      mgmt_sda_in <= select_active ? sda_in : 1'b1;
      sda_oe      <= select_active & functional & mgmt_sda_drive_low;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      low_power_mode <= 1'b0;
    end else begin
      low_power_mode <= low_power_request;
    end
  end

  // reset pin low-time measurement
  always @(posedge clk) begin
    if (rst) begin
      reset_prev <= 1'b1;
      low_count  <= 27'h0000000;
      long_low   <= 1'b0;
    end else begin
      reset_prev <= module_reset_n;
      if (module_reset_n) begin
        low_count <= 27'h0000000;
        long_low  <= 1'b0;
      end else if (low_count >= RESET_PULSE_CYC - 27'h0000001) begin
        long_low <= 1'b1;
      end else begin
        low_count <= low_count + 27'h0000001;
      end
    end
  end

  always @* begin
    next_state = state;
    t_start    = 1'b0;
    t_len      = RESET_EXEC_CYC;
    case (state)
      ST_POWERUP: begin
        if (long_low) begin
          next_state = ST_RESET;
        end else if (t_done) begin
          next_state = ST_RUN;
        end
      end
      ST_RESET: begin
        if (reset_rise) begin
          next_state = ST_EXEC;
          t_start    = 1'b1;
        end
      end
      ST_EXEC: begin
        if (long_low) begin
          next_state = ST_RESET;
        end else if (t_done) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (long_low) begin
          next_state = ST_RESET;
        end
      end
      default: begin
        next_state = ST_POWERUP;
      end
    endcase
  end

  // a reset pin low held past the minimum width aborts power-up too
  always @(posedge clk) begin
    if (rst) begin
      state            <= ST_POWERUP;
      init_pending     <= 1'b1;
      functional       <= 1'b0;
      defaults_restore <= 1'b0;
      attn_done        <= 1'b0;
    end else begin
      state            <= next_state;
      defaults_restore <= (next_state == ST_RESET) && (state != ST_RESET);
      if (next_state == ST_RESET) begin
        init_pending <= 1'b1;
        functional   <= 1'b0;
        attn_done    <= 1'b0;
      end else if (state != ST_RUN && next_state == ST_RUN) begin
        init_pending <= 1'b0;
        functional   <= 1'b1;
        attn_done    <= 1'b1;
      end else if (flags_read) begin
        attn_done <= 1'b0;
      end
    end
  end

  // power-up timer kick on the first cycle after rst
  always @(posedge clk) begin
    if (rst) begin
      pu_kicked <= 1'b0;
    end else begin
      pu_kicked <= 1'b1;
    end
  end

  // fault flag: set wins over the host's read-to-clear
  always @(posedge clk) begin
    if (rst) begin
      attn_fault <= 1'b0;
    end else if (fault_event & functional) begin
      attn_fault <= 1'b1;
    end else if (flags_read) begin
      attn_fault <= 1'b0;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      attention_n_oe <= 1'b0;
    end else begin
      attention_n_oe <= attn_done | attn_fault;
    end
  end

endmodule // msbc_sideband

// [msbc_sideband_properties.sv]
// concurrent checks on the sideband block ports
`timescale 1ns/1ps
module msbc_sideband_properties (
  // clock, reset and host pins
  input wire clk, rst, module_select_n_in, module_select_n_oe, low_power_request,
  input wire module_present_n, attention_n_o, attention_n_oe, sda_o, sda_oe,
  // engine side
  input wire mgmt_enable, fault_event, low_power_mode, init_pending, functional
);
  // undriven select floats high through the internal pull-up
  wire desel = !module_select_n_oe | module_select_n_in;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_sda_released: assert property (desel [*3] |-> !sda_oe)
    else $error("data line driven while deselected");
  a_mgmt_blocked: assert property (desel [*3] |-> !mgmt_enable)
    else $error("bus traffic passed while deselected");
  a_mgmt_open: assert property ((!desel && functional) [*3] |-> mgmt_enable)
    else $error("bus traffic blocked while selected");
  a_attn_pull_only: assert property (attention_n_oe |-> !attention_n_o)
    else $error("attention driven high");
  a_sda_pull_only: assert property (sda_oe |-> !sda_o)
    else $error("data line driven high");
  a_present_low: assert property (!module_present_n)
    else $error("presence not low");
  a_lp_follow: assert property ($stable(low_power_request) [*3] |->
    low_power_mode == low_power_request)
    else $error("low power mode does not follow request");
  a_fault_attn: assert property ($rose(fault_event) && functional |-> ##[0:3] attention_n_oe)
    else $error("fault without attention");
  a_done_attn: assert property ($fell(init_pending) |-> ##[0:2] attention_n_oe)
    else $error("reset completion without attention");
  cover property ($fell(init_pending));
  cover property ($rose(fault_event) && functional);
  cover property (desel ##1 !desel);
endmodule // msbc_sideband_properties

bind msbc_sideband msbc_sideband_properties u_props (.clk, .rst, .module_select_n_in,
  .module_select_n_oe, .low_power_request, .module_present_n, .attention_n_o, .attention_n_oe,
  .sda_o, .sda_oe, .mgmt_enable, .fault_event, .low_power_mode, .init_pending, .functional);

// [msbc_timer.v]
// cycle timer that pulses done once after a start
`timescale 1ns/1ps
module msbc_timer #(
  parameter W = 27
) (
  // clock and reset
  input  wire         clk,
  input  wire         rst,
  // control
  input  wire         start,
  input  wire [W-1:0] length,
  // status
  output reg          busy,
  output reg          done
);
  reg [W-1:0] count;

  always @(posedge clk) begin
    if (rst) begin
      busy  <= 1'b0;
      done  <= 1'b0;
      count <= {W{1'b0}};
    end else begin
      done <= 1'b0;
      if (start) begin
        busy  <= 1'b1;
        count <= length;
      end else if (busy) begin
        if (count <= {{(W-1){1'b0}}, 1'b1}) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // msbc_timer

// [tb_top.sv]
// self-checking bench for the sideband block
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_top;
  localparam [26:0] PULSE = 27'h4, EXEC = 27'h14, PWR = 27'h1E;
  reg clk = 0, rst = 1, module_select_n_in = 1, module_select_n_oe = 0, module_reset_n = 1;
  reg low_power_request = 0, host_sda_low = 0, mgmt_sda_drive_low = 0, fault_event = 0, f = 0;
  wire module_present_n, attention_n_o, attention_n_oe, sda_oe, sda_o, mgmt_enable, mgmt_sda_in;
  wire defaults_restore, low_power_mode, init_pending, functional, flags_read;
  wire attn_line, present_line, sda_line, d;
  integer mismatches = 0, compares = 0, cycles = 0, n, i, k, restores = 0, attn_cnt = 0;
  always #12.5 clk = ~clk;
  msbc_sideband #(.RESET_PULSE_CYC(PULSE), .RESET_EXEC_CYC(EXEC), .POWERUP_CYC(PWR))
    u_msbc_sideband (.clk, .rst, .module_select_n_in, .module_select_n_oe, .module_reset_n,
    .low_power_request, .module_present_n, .attention_n_o, .attention_n_oe, .sda_in(sda_line),
    .sda_oe, .sda_o, .mgmt_enable, .mgmt_sda_in, .mgmt_sda_drive_low, .fault_event, .flags_read,
    .defaults_restore, .low_power_mode, .init_pending, .functional);
  msbc_host_model u_msbc_host_model (.clk, .attention_n_o, .attention_n_oe, .module_present_n,
    .sda_o, .sda_oe, .host_sda_low, .attn_line, .present_line, .sda_line, .flags_read);
  assign d = !module_select_n_oe | module_select_n_in;
  always @(posedge clk) begin
    if (defaults_restore === 1'b1) restores <= restores + 1;
    if (attn_line === 1'b0) attn_cnt <= attn_cnt + 1;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      conclude;
    end
  end
  task conclude;
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // host waits for the completion attention, never a fixed delay
  task wait_done(input integer lim);
    n = 0;
    while (attn_line !== 1'b0 && n < lim) begin
      @(negedge clk);
      n = n + 1;
    end
    `CHK("completion", 1'b0, attn_line)
    `CHK("init_pending", 1'b0, init_pending)
  endtask
  initial begin
    n = $urandom(32'h8aec);
    repeat (3) @(negedge clk);
    rst = 0;
    wait_done(PWR + 10);
    `CHK("functional", 1'b1, functional)
    `CHK("present", 1'b0, present_line)
    // let the completion attention and its read-back die away
    repeat (4) @(negedge clk);
    for (i = 0; i < 60; i = i + 1) begin
      {module_select_n_in, module_select_n_oe, low_power_request} = $urandom;
      {host_sda_low, mgmt_sda_drive_low} = $urandom;
      fault_event = ($urandom % 6) == 0;
      k = attn_cnt;
      @(negedge clk);
      f = fault_event;
      fault_event = 0;
      // attention, flag read and release all settle within five cycles
      repeat (5) @(negedge clk);
      `CHK("mgmt_enable", !d, mgmt_enable)
      `CHK("sda_oe", !d & mgmt_sda_drive_low, sda_oe)
      `CHK("mgmt_sda_in", d | !(host_sda_low | mgmt_sda_drive_low), mgmt_sda_in)
      `CHK("low_power", low_power_request, low_power_mode)
      `CHK("attention", f, attn_cnt != k)
    end
    repeat (6) @(negedge clk);
    k = restores;
    module_reset_n = 0;
    repeat (PULSE - 2) @(negedge clk);
    module_reset_n = 1;
    repeat (4) @(negedge clk);
    `CHK("short_reset", k, restores)
    `CHK("still_up", 1'b1, functional)
    module_reset_n = 0;
    repeat (PULSE + 2) @(negedge clk);
    `CHK("restore", k + 1, restores)
    module_reset_n = 1;
    repeat (2) @(negedge clk);
    `CHK("pending", 1'b1, init_pending)
    `CHK("down", 1'b0, functional)
    wait_done(EXEC + 10);
    `CHK("exec_time", 1'b1, n + 2 >= EXEC)
    conclude;
  end
endmodule // tb_top
